// >>> hw/mmc_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MMC_DEFINES_SVH
`define MMC_DEFINES_SVH

`define MMC_REF_CLK_MHZ     250
`define MMC_DEV_ADDR        7'h50

`define MMC_OFS_STATUS      8'h02
`define MMC_OFS_FLAG_LANE   8'h03
`define MMC_OFS_FLAG_MOD    8'h04
`define MMC_OFS_LIVE        8'h06
`define MMC_OFS_POWER       8'h5d
`define MMC_OFS_MASK_LANE   8'h64
`define MMC_OFS_MASK_MOD    8'h65
`define MMC_OFS_TX_EQ_HI    8'hea
`define MMC_OFS_TX_EQ_LO    8'heb
`define MMC_OFS_RX_EMPH_HI  8'hec
`define MMC_OFS_RX_EMPH_LO  8'hed
`define MMC_OFS_RX_AMP_HI   8'hee
`define MMC_OFS_RX_AMP_LO   8'hef

`define MMC_BIT_DNR         0
`define MMC_BIT_INIT_DONE   0
`define MMC_BIT_PDOWN       0

`define MMC_EQ_MAX          4'ha
`define MMC_EMPH_MAX        4'h7
`define MMC_AMP_MAX         4'h3
`define MMC_LANE_RESET      16'h0000
`define MMC_UNMAPPED        8'h00

`define MMC_RESET_MIN_US    2
`define MMC_RESET_MIN_CYC   (`MMC_RESET_MIN_US * `MMC_REF_CLK_MHZ)
`define MMC_INIT_MS         2000
`define MMC_INIT_CYC        (`MMC_INIT_MS * 1000 * `MMC_REF_CLK_MHZ)

`endif

// >>> hw/mmc_mgmt_ctrl.sv
// Management control and status core of a four-lane pluggable module
`timescale 1ns/1ns
`include "mmc_defines.svh"
module mmc_mgmt_ctrl
  import mmc_pkg::*;
#(
  parameter int INIT_CYCLES = `MMC_INIT_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        bus_clk_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n_out,
  input  wire logic        module_select_n_in,
  input  wire logic        module_reset_n_in,
  input  wire logic        low_power_select_in,
  input  wire logic [3:0]  rx_los_in,
  input  wire logic [3:0]  tx_fault_in,
  input  wire logic        monitor_valid_in,
  output logic             module_alert_n_out,
  output logic             low_power_out,
  output logic [15:0]      tx_eq_out,
  output logic [15:0]      rx_emph_out,
  output logic [15:0]      rx_amp_out
);

  localparam mmc_core_t CORE_RST = '{
    tx_eq:     `MMC_LANE_RESET,
    rx_emph:   `MMC_LANE_RESET,
    rx_amp:    `MMC_LANE_RESET,
    dnr:       1'b1,
    alert_n:   1'b1,
    default:   '0
  };

  mmc_xfer_if xfer ();

  mmc_core_t   s;
  mmc_core_t   next_s;
  logic [10:0] pins;
  logic        req_s;
  logic [3:0]  los;
  logic [3:0]  txf;
  logic        rst_pin_n;
  logic        lp_sel;
  logic        mon_ok;

  mmc_serial u_serial (
    .bus_clk_in         (bus_clk_in),
    .rst_b_in           (rst_b_in),
    .scl_in             (scl_in),
    .sda_in             (sda_in),
    .module_select_n_in (module_select_n_in),
    .sda_out            (sda_out),
    .sda_oe_n_out       (sda_oe_n_out),
    .xfer               (xfer.serial)
  );

  mmc_sync3 #(.W(11), .INIT(11'h100)) u_pins (
    .clk_in   (ref_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     ({monitor_valid_in, low_power_select_in, module_reset_n_in,
                tx_fault_in, rx_los_in}),
    .q_out    (pins)
  );

  mmc_sync3 #(.W(1), .INIT(1'b0)) u_req (
    .clk_in   (ref_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (xfer.req_tgl),
    .q_out    (req_s)
  );

  assign los       = pins[3:0];
  assign txf       = pins[7:4];
  assign rst_pin_n = pins[8];
  assign lp_sel    = pins[9];
  assign mon_ok    = pins[10];

  // Reserved codes are refused nibble by nibble
  function automatic logic code_ok(mmc_code_t kind, logic [3:0] code);
    logic ok;
    ok = 1'b0;
    case (kind)
      CODE_EQ:   ok = (code <= `MMC_EQ_MAX);
      CODE_EMPH: ok = (code <= `MMC_EMPH_MAX);
      CODE_AMP:  ok = (code <= `MMC_AMP_MAX);
      default:   ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Even offset holds lanes 1 and 2, odd offset lanes 3 and 4
  function automatic logic [15:0] lane_write(mmc_code_t kind,
                                             logic [15:0] old,
                                             logic hi, logic [7:0] d);
    logic [7:0] cur;
    logic [7:0] upd;
    cur      = hi ? old[15:8] : old[7:0];
    upd[7:4] = code_ok(kind, d[7:4]) ? d[7:4] : cur[7:4];
    upd[3:0] = code_ok(kind, d[3:0]) ? d[3:0] : cur[3:0];
    return hi ? {upd, old[7:0]} : {old[15:8], upd};
  endfunction

  function automatic logic [7:0] reg_read(mmc_core_t x, logic [7:0] a,
                                          logic [3:0] l, logic [3:0] t);
    logic [7:0] r;
    r = `MMC_UNMAPPED;
    case (a)
      `MMC_OFS_STATUS:     r[`MMC_BIT_DNR] = x.dnr;
      `MMC_OFS_FLAG_LANE:  r = {x.txf_flag, x.los_flag};
      `MMC_OFS_FLAG_MOD:   r[`MMC_BIT_INIT_DONE] = x.init_flag;
      `MMC_OFS_LIVE:       r = {t, l};
      `MMC_OFS_POWER:      r[`MMC_BIT_PDOWN] = x.pdown;
      `MMC_OFS_MASK_LANE:  r = {x.txf_mask, x.los_mask};
      `MMC_OFS_MASK_MOD:   r[`MMC_BIT_INIT_DONE] = x.init_mask;
      `MMC_OFS_TX_EQ_HI:   r = x.tx_eq[15:8];
      `MMC_OFS_TX_EQ_LO:   r = x.tx_eq[7:0];
      `MMC_OFS_RX_EMPH_HI: r = x.rx_emph[15:8];
      `MMC_OFS_RX_EMPH_LO: r = x.rx_emph[7:0];
      `MMC_OFS_RX_AMP_HI:  r = x.rx_amp[15:8];
      `MMC_OFS_RX_AMP_LO:  r = x.rx_amp[7:0];
      default:             r = `MMC_UNMAPPED;
    endcase
    return r;
  endfunction

  always_comb begin
    logic [3:0] los_rise;
    logic [3:0] txf_rise;
    logic       req_new;
    logic       keep_ack;
    logic       keep_req;
    los_rise = los & ~s.los_prev;
    txf_rise = txf & ~s.txf_prev;
    req_new  = (req_s != s.req_seen);
    keep_ack = 1'b0;
    keep_req = 1'b0;
    next_s   = s;
    next_s.los_prev = los;
    next_s.txf_prev = txf;

    // Long enough low on the reset pin becomes a reset request
    if (!rst_pin_n) begin
      if (s.rst_cnt != 10'(`MMC_RESET_MIN_CYC)) begin
        next_s.rst_cnt = s.rst_cnt + 10'h001;
      end else begin
        next_s.in_reset = 1'b1;
      end
    end else begin
      next_s.rst_cnt = 10'h000;
    end

    // Data-not-ready ends on valid monitors or the init deadline
    if (s.dnr && !s.in_reset) begin
      next_s.init_cnt = s.init_cnt + 29'h1;
      if (mon_ok || s.init_cnt == 29'(INIT_CYCLES - 1)) begin
        next_s.dnr       = 1'b0;
        next_s.init_flag = 1'b1;
      end
    end

    if (req_new) begin
      next_s.req_seen = req_s;
      next_s.ack_tgl  = ~s.ack_tgl;
      if (xfer.op_wr) begin
        case (xfer.addr)
          `MMC_OFS_MASK_LANE: begin
            next_s.los_mask = xfer.wdata[3:0];
            next_s.txf_mask = xfer.wdata[7:4];
          end
          `MMC_OFS_MASK_MOD:
            next_s.init_mask = xfer.wdata[`MMC_BIT_INIT_DONE];
          `MMC_OFS_POWER:
            next_s.pdown = xfer.wdata[`MMC_BIT_PDOWN];
          `MMC_OFS_TX_EQ_HI:
            next_s.tx_eq = lane_write(CODE_EQ, s.tx_eq, 1'b1, xfer.wdata);
          `MMC_OFS_TX_EQ_LO:
            next_s.tx_eq = lane_write(CODE_EQ, s.tx_eq, 1'b0, xfer.wdata);
          `MMC_OFS_RX_EMPH_HI:
            next_s.rx_emph = lane_write(CODE_EMPH, s.rx_emph, 1'b1,
                                        xfer.wdata);
          `MMC_OFS_RX_EMPH_LO:
            next_s.rx_emph = lane_write(CODE_EMPH, s.rx_emph, 1'b0,
                                        xfer.wdata);
          `MMC_OFS_RX_AMP_HI:
            next_s.rx_amp = lane_write(CODE_AMP, s.rx_amp, 1'b1,
                                       xfer.wdata);
          `MMC_OFS_RX_AMP_LO:
            next_s.rx_amp = lane_write(CODE_AMP, s.rx_amp, 1'b0,
                                       xfer.wdata);
          default: ;
        endcase
      end else begin
        next_s.rdata = reg_read(s, xfer.addr, los, txf);
        if (xfer.commit) begin
          // Only the bits actually shown to the host are cleared
          case (xfer.caddr)
            `MMC_OFS_FLAG_LANE: begin
              next_s.los_flag = s.los_flag & ~s.rdata[3:0];
              next_s.txf_flag = s.txf_flag & ~s.rdata[7:4];
            end
            `MMC_OFS_FLAG_MOD:
              next_s.init_flag = next_s.init_flag &
                                 ~s.rdata[`MMC_BIT_INIT_DONE];
            default: ;
          endcase
        end
      end
    end

    // New events after any clear, so a set wins over a same-cycle clear
    if (!s.dnr) begin
      next_s.los_flag = next_s.los_flag | los_rise;
      next_s.txf_flag = next_s.txf_flag | txf_rise;
    end

    // Alert follows unmasked flags one cycle later
    next_s.alert_n = ~((s.init_flag & ~s.init_mask) |
                       (|(s.los_flag & ~s.los_mask)) |
                       (|(s.txf_flag & ~s.txf_mask)));

    next_s.low_power = lp_sel | s.pdown;

    // Reset request holds all but the handshake, edge history and low power at reset values until the pin rises
    if (s.in_reset) begin
      keep_ack          = next_s.ack_tgl;
      keep_req          = next_s.req_seen;
      next_s            = CORE_RST;
      next_s.ack_tgl    = keep_ack;
      next_s.req_seen   = keep_req;
      next_s.los_prev   = los;
      next_s.txf_prev   = txf;
      next_s.in_reset   = ~rst_pin_n;
      next_s.low_power  = lp_sel;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= CORE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign xfer.ack_tgl       = s.ack_tgl;
  assign xfer.rdata         = s.rdata;
  assign module_alert_n_out = s.alert_n;
  assign low_power_out      = s.low_power;
  assign tx_eq_out          = s.tx_eq;
  assign rx_emph_out        = s.rx_emph;
  assign rx_amp_out         = s.rx_amp;

endmodule

// >>> hw/mmc_pkg.sv
// Types shared by the management control block
package mmc_pkg;

  typedef enum logic [1:0] {CODE_EQ, CODE_EMPH, CODE_AMP} mmc_code_t;

  typedef enum logic [2:0] {
    SER_IDLE, SER_ADDR, SER_ACK_ADDR, SER_WRITE, SER_ACK_WR, SER_READ,
    SER_ACK_RD
  } mmc_ser_st_t;

  typedef struct packed {
    mmc_ser_st_t st;
    logic        scl_d;
    logic        sda_d;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        got_ptr;
    logic        rw;
    logic        hold;
    logic        req_tgl;
    logic        op_wr;
    logic        commit;
    logic [7:0]  addr;
    logic [7:0]  caddr;
    logic [7:0]  wdata;
  } mmc_ser_t;

  typedef struct packed {
    logic [15:0] tx_eq;
    logic [15:0] rx_emph;
    logic [15:0] rx_amp;
    logic        dnr;
    logic        init_flag;
    logic        init_mask;
    logic        pdown;
    logic        in_reset;
    logic        ack_tgl;
    logic        req_seen;
    logic        alert_n;
    logic        low_power;
    logic [28:0] init_cnt;
    logic [9:0]  rst_cnt;
    logic [3:0]  los_flag;
    logic [3:0]  txf_flag;
    logic [3:0]  los_mask;
    logic [3:0]  txf_mask;
    logic [3:0]  los_prev;
    logic [3:0]  txf_prev;
    logic [7:0]  rdata;
  } mmc_core_t;

endpackage

// >>> hw/mmc_serial.sv
// Two-wire management bus slave on the bus-side clock
`timescale 1ns/1ns
`include "mmc_defines.svh"
module mmc_serial
  import mmc_pkg::*;
(
  input  wire logic   bus_clk_in,
  input  wire logic   rst_b_in,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  input  wire logic   module_select_n_in,
  output logic        sda_out,
  output logic        sda_oe_n_out,
  mmc_xfer_if.serial  xfer
);

  mmc_ser_t   s;
  mmc_ser_t   next_s;
  logic [2:0] pins;
  logic       ack_s;
  logic       scl;
  logic       sda;
  logic       sel_n;

  mmc_sync3 #(.W(3), .INIT(3'b111)) u_pins (
    .clk_in   (bus_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     ({module_select_n_in, scl_in, sda_in}),
    .q_out    (pins)
  );

  mmc_sync3 #(.W(1), .INIT(1'b0)) u_ack (
    .clk_in   (bus_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (xfer.ack_tgl),
    .q_out    (ack_s)
  );

  assign sel_n = pins[2];
  assign scl   = pins[1];
  assign sda   = pins[0];

  function automatic mmc_ser_t issue(mmc_ser_t x, logic wr, logic cm,
                                     logic [7:0] a, logic [7:0] ca,
                                     logic [7:0] d);
    mmc_ser_t y;
    y         = x;
    y.req_tgl = ~x.req_tgl;
    y.op_wr   = wr;
    y.commit  = cm;
    y.addr    = a;
    y.caddr   = ca;
    y.wdata   = d;
    return y;
  endfunction

  always_comb begin
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic free;
    start        = scl & s.scl_d & s.sda_d & ~sda;
    stop         = scl & s.scl_d & ~s.sda_d & sda;
    rise         = scl & ~s.scl_d;
    fall         = ~scl & s.scl_d;
    free         = (ack_s == s.req_tgl);
    next_s       = s;
    next_s.scl_d = scl;
    next_s.sda_d = sda;
    if (start) begin
      next_s.st      = SER_ADDR;
      next_s.bitcnt  = 4'h0;
      next_s.got_ptr = 1'b0;
      next_s.hold    = 1'b0;
    end else if (stop) begin
      next_s.st   = SER_IDLE;
      next_s.hold = 1'b0;
    end else begin
      case (s.st)
        SER_ADDR, SER_WRITE: begin
          if (rise) begin
            next_s.shreg  = {s.shreg[6:0], sda};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end else if (fall && s.bitcnt == 4'h8) begin
            if (s.st == SER_ADDR) begin
              // Deselected module ignores its address
              if (s.shreg[7:1] == `MMC_DEV_ADDR && !sel_n) begin
                next_s.hold = 1'b1;
                next_s.rw   = s.shreg[0];
                next_s.st   = SER_ACK_ADDR;
                if (s.shreg[0] && free) begin
                  next_s = issue(next_s, 1'b0, 1'b0, s.ptr, s.ptr, 8'h00);
                end
              end else begin
                next_s.st = SER_IDLE;
              end
            end else begin
              next_s.hold = 1'b1;
              next_s.st   = SER_ACK_WR;
              if (!s.got_ptr) begin
                next_s.ptr     = s.shreg;
                next_s.got_ptr = 1'b1;
              end else if (free) begin
                // Write takes effect on arrival of its byte
                next_s     = issue(next_s, 1'b1, 1'b0, s.ptr, s.ptr, s.shreg);
                next_s.ptr = s.ptr + 8'h01;
              end
            end
          end
        end
        SER_ACK_ADDR, SER_ACK_WR, SER_ACK_RD: begin
          if (s.st == SER_ACK_RD && rise && sda) begin
            next_s.st = SER_IDLE;
          end else if (fall) begin
            next_s.bitcnt = 4'h0;
            if (s.st == SER_ACK_WR || !s.rw) begin
              next_s.hold = 1'b0;
              next_s.st   = SER_WRITE;
            end else begin
              next_s.shreg = xfer.rdata;
              next_s.hold  = ~xfer.rdata[7];
              next_s.st    = SER_READ;
            end
          end
        end
        SER_READ: begin
          if (fall) begin
            if (s.bitcnt == 4'h7) begin
              // Byte fully shifted: commit its read, prefetch the next
              next_s.hold = 1'b0;
              next_s.st   = SER_ACK_RD;
              if (free) begin
                next_s = issue(next_s, 1'b0, 1'b1, s.ptr + 8'h01, s.ptr,
                               8'h00);
              end
              next_s.ptr = s.ptr + 8'h01;
            end else begin
              next_s.shreg  = {s.shreg[6:0], 1'b0};
              next_s.hold   = ~s.shreg[6];
              next_s.bitcnt = s.bitcnt + 4'h1;
            end
          end
        end
        default: begin
          next_s.st   = SER_IDLE;
          next_s.hold = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge bus_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s       <= '0;
      s.scl_d <= 1'b1;
      s.sda_d <= 1'b1;
      s.st    <= SER_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~s.hold;
  assign xfer.req_tgl = s.req_tgl;
  assign xfer.op_wr   = s.op_wr;
  assign xfer.commit  = s.commit;
  assign xfer.addr    = s.addr;
  assign xfer.caddr   = s.caddr;
  assign xfer.wdata   = s.wdata;

endmodule

// >>> hw/mmc_sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module mmc_sync3
  import mmc_pkg::*;
#(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } mmc_sync_t;

  mmc_sync_t s;
  mmc_sync_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = d_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.q  = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.q);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
    end else begin
      s <= next_s;
    end
  end

  assign q_out = s.q;

endmodule

// >>> hw/mmc_xfer_if.sv
// Byte transfer handshake between serial engine and register core
`timescale 1ns/1ns
interface mmc_xfer_if;
  logic       req_tgl;
  logic       op_wr;
  logic       commit;
  logic [7:0] addr;
  logic [7:0] caddr;
  logic [7:0] wdata;
  logic       ack_tgl;
  logic [7:0] rdata;

  modport serial (output req_tgl, op_wr, commit, addr, caddr, wdata,
                  input  ack_tgl, rdata);
  modport core   (input  req_tgl, op_wr, commit, addr, caddr, wdata,
                  output ack_tgl, rdata);
endinterface

// >>> tb/mmc_checker.sv
// Port-level assertions for the management control block
`timescale 1ns/1ns
module mmc_checker
  import mmc_pkg::*;
#(
  parameter int INIT_CYCLES = 2000
) (
  input wire logic        ref_clk_in,
  input wire logic        rst_b_in,
  input wire logic        bus_clk_in,
  input wire logic        scl_in,
  input wire logic        module_select_n_in,
  input wire logic        module_reset_n_in,
  input wire logic        low_power_select_in,
  input wire logic [3:0]  rx_los_in,
  input wire logic [3:0]  tx_fault_in,
  input wire logic        module_alert_n_out,
  input wire logic        low_power_out,
  input wire logic        sda_oe_n_out,
  input wire logic [15:0] tx_eq_out,
  input wire logic [15:0] rx_emph_out,
  input wire logic [15:0] rx_amp_out
);
  localparam int INIT_MAX = INIT_CYCLES + 64;
  localparam int SEL_OFF  = 25000;
  logic [15:0] sel_cnt;
  logic [9:0]  rst_cnt;
  logic [31:0] init_cnt;
  logic        armed;

  function automatic logic [3:0] max_nib(input logic [15:0] v);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) if (v[4*i+:4] > m) m = v[4*i+:4];
    return m;
  endfunction

  // Counts: deselect time, reset pin low time, time until ready
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel_cnt  <= '0;
      rst_cnt  <= '0;
      init_cnt <= '0;
      armed    <= 1'b1;
    end else begin
      sel_cnt  <= !module_select_n_in ? '0 :
                  (sel_cnt == SEL_OFF) ? sel_cnt : sel_cnt + 16'h0001;
      rst_cnt  <= module_reset_n_in ? '0 :
                  (&rst_cnt) ? rst_cnt : rst_cnt + 10'h001;
      init_cnt <= (armed && module_reset_n_in) ? init_cnt + 32'h1 : '0;
      if (rst_cnt == 10'h208) begin
        armed <= 1'b1;
      end else if (!module_alert_n_out) begin
        armed <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_init_deadline: assert property (init_cnt <= INIT_MAX)
    else $error("alert not asserted after init");
  a_soft_reset: assert property (rst_cnt == 10'h208 |->
    module_alert_n_out && tx_eq_out == 16'h0000 && rx_amp_out == 16'h0000)
    else $error("soft reset did not clear state");
  a_lp_follow: assert property (low_power_select_in [*8] |->
    low_power_out) else $error("low power not entered");
  a_sel_quiet: assert property (sel_cnt == SEL_OFF |->
    sda_oe_n_out) else $error("bus driven while deselected");
  a_eq_legal: assert property (max_nib(tx_eq_out) <= 4'ha)
    else $error("equalization code out of range");
  a_emph_legal: assert property (max_nib(rx_emph_out) <= 4'h7)
    else $error("emphasis code out of range");
  a_amp_legal: assert property (max_nib(rx_amp_out) <= 4'h3)
    else $error("amplitude code out of range");
  a_los_alert: assert property (!armed && $rose(rx_los_in[0])
    ##1 rx_los_in[0] [*7] |-> ##[1:16] !module_alert_n_out)
    else $error("loss of signal did not alert");
  a_fault_alert: assert property (!armed && $rose(tx_fault_in[0])
    ##1 tx_fault_in[0] [*7] |-> ##[1:16] !module_alert_n_out)
    else $error("transmit fault did not alert");
  a_sda_edge: assert property (@(posedge bus_clk_in)
    disable iff (!rst_b_in) $changed(sda_oe_n_out) |-> !scl_in)
    else $error("data line changed while clock high");

  c_los: cover property ($rose(rx_los_in[0]));
  c_alert: cover property ($fell(module_alert_n_out));
  c_ack: cover property (@(posedge bus_clk_in) $fell(sda_oe_n_out));
endmodule

// >>> tb/mmc_host_model.sv
// Host controller model driving the two-wire management bus
`timescale 1ns/1ns
module mmc_host_model #(
  parameter int Q = 625
) (
  output logic      scl_out,
  output logic      sda_low_out,
  input  wire logic sda_in
);
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  // One bit per 4Q, data changes only while clock low
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = !b;
    #Q scl_out = 1'b1;
    #Q r = sda_in;
    #Q scl_out = 1'b0;
    #Q;
  endtask

  // Also serves as repeated start
  task automatic start_cond();
    sda_low_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q sda_low_out = 1'b1;
    #Q scl_out = 1'b0;
    #Q;
  endtask

  task automatic stop_cond();
    sda_low_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_low_out = 1'b0;
    #Q;
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// >>> tb/mmc_mgmt_ctrl_tb.sv
// Self-checking bench for the management control block
`timescale 1ns/1ns
`include "mmc_defines.svh"
module mmc_mgmt_ctrl_tb
  import mmc_pkg::*;
();
  localparam int INIT = 2000;
  logic        ref_clk, bus_clk, rst_b, sel_n, mrst_n, lp_sel, mon_ok;
  logic [3:0]  los, txf;
  logic        scl, host_low, sda, sda_o, oe_n, alert_n, lp_out;
  logic [15:0] eq, emph, amp;
  logic [7:0]  rd[$];
  int          fails = 0;
  int          compares = 0;

  // Pull-up wire: low when either side pulls
  assign sda = !host_low && (oe_n || sda_o);

  mmc_mgmt_ctrl #(.INIT_CYCLES(INIT)) mmc_mgmt_ctrl_inst (
    .ref_clk_in(ref_clk), .rst_b_in(rst_b), .bus_clk_in(bus_clk),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(oe_n),
    .module_select_n_in(sel_n), .module_reset_n_in(mrst_n),
    .low_power_select_in(lp_sel), .rx_los_in(los), .tx_fault_in(txf),
    .monitor_valid_in(mon_ok), .module_alert_n_out(alert_n),
    .low_power_out(lp_out), .tx_eq_out(eq), .rx_emph_out(emph),
    .rx_amp_out(amp));
  mmc_host_model mmc_host_model_inst (
    .scl_out(scl), .sda_low_out(host_low), .sda_in(sda));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = !ref_clk;
  end
  initial begin
    bus_clk = 1'b0;
    #37;
    forever begin
      #62 bus_clk = 1'b1;
      #63 bus_clk = 1'b0;
    end
  end

  task automatic conclude();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wait_alert(input logic lvl, input int max);
    for (int n = 0; n < max && alert_n !== lvl; n++) @(negedge ref_clk);
    chk({15'h0, alert_n}, {15'h0, lvl});
  endtask

  task automatic bus_hdr(input logic [7:0] ofs);
    logic a;
    mmc_host_model_inst.start_cond();
    mmc_host_model_inst.send({`MMC_DEV_ADDR, 1'b0}, a);
    chk({15'h0, a}, 16'h0001);
    mmc_host_model_inst.send(ofs, a);
  endtask

  task automatic bus_write(input logic [7:0] ofs, input logic [7:0] d[$]);
    logic a;
    bus_hdr(ofs);
    foreach (d[i]) mmc_host_model_inst.send(d[i], a);
    mmc_host_model_inst.stop_cond();
  endtask

  task automatic bus_read(input logic [7:0] ofs, input int n);
    logic       a;
    logic [7:0] b;
    bus_hdr(ofs);
    mmc_host_model_inst.start_cond();
    mmc_host_model_inst.send({`MMC_DEV_ADDR, 1'b1}, a);
    rd.delete();
    for (int i = 0; i < n; i++) begin
      mmc_host_model_inst.recv(i == n - 1, b);
      rd.push_back(b);
    end
    mmc_host_model_inst.stop_cond();
  endtask

  task automatic t_init();
    chk(eq, 16'h0000);
    ticks(INIT - 100);
    chk({15'h0, alert_n}, 16'h0001);
    wait_alert(1'b0, 300);
  endtask

  // Boundary and reserved codes; reserved nibbles keep old value
  task automatic t_codes();
    bus_write(`MMC_OFS_TX_EQ_LO, '{8'hab, 8'h78, 8'h05, 8'h34});
    ticks(50);
    chk(eq, 16'h00a0);
    chk(emph, 16'h7005);
    chk(amp, 16'h3000);
  endtask

  task automatic t_unsel();
    logic a;
    @(negedge ref_clk);
    sel_n = 1'b1;
    ticks(500);
    mmc_host_model_inst.start_cond();
    mmc_host_model_inst.send({`MMC_DEV_ADDR, 1'b0}, a);
    mmc_host_model_inst.stop_cond();
    chk({15'h0, a}, 16'h0000);
    @(negedge ref_clk);
    sel_n = 1'b0;
    ticks(500);
  endtask

  task automatic t_flags();
    @(negedge ref_clk);
    los[0] = 1'b1;
    txf[0] = 1'b1;
    ticks(40);
    bus_read(`MMC_OFS_FLAG_LANE, 2);
    chk({8'h00, rd[0]}, 16'h0011);
    chk({8'h00, rd[1]}, 16'h0001);
    wait_alert(1'b1, 2000);
    @(negedge ref_clk);
    los[0] = 1'b0;
    ticks(20);
    los[0] = 1'b1;
    wait_alert(1'b0, 40);
  endtask

  task automatic t_lp();
    @(negedge ref_clk);
    lp_sel = 1'b1;
    ticks(10);
    chk({15'h0, lp_out}, 16'h0001);
    lp_sel = 1'b0;
    ticks(10);
    chk({15'h0, lp_out}, 16'h0000);
  endtask

  // Short pulse ignored, long pulse resets and restarts init
  task automatic t_soft();
    @(negedge ref_clk);
    mrst_n = 1'b0;
    ticks(100);
    mrst_n = 1'b1;
    ticks(50);
    chk(eq, 16'h00a0);
    mon_ok = 1'b1;
    mrst_n = 1'b0;
    ticks(600);
    chk({15'h0, alert_n}, 16'h0001);
    chk(emph, 16'h0000);
    mrst_n = 1'b1;
    wait_alert(1'b0, 100);
  endtask

  initial begin
    rst_b = 1'b0;
    sel_n = 1'b0;
    mrst_n = 1'b1;
    lp_sel = 1'b0;
    mon_ok = 1'b0;
    los = 4'h0;
    txf = 4'h0;
    repeat (3) @(negedge bus_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    t_init();
    t_codes();
    t_unsel();
    t_flags();
    t_lp();
    t_soft();
    sel_n = 1'b1;
    ticks(25100);
    conclude();
  end

  initial begin
    #900000;
    fails++;
    conclude();
  end
endmodule

bind mmc_mgmt_ctrl mmc_checker #(.INIT_CYCLES(INIT_CYCLES)) mmc_checker_inst (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .bus_clk_in(bus_clk_in),
  .scl_in(scl_in), .module_select_n_in(module_select_n_in),
  .module_reset_n_in(module_reset_n_in),
  .low_power_select_in(low_power_select_in), .rx_los_in(rx_los_in),
  .tx_fault_in(tx_fault_in), .module_alert_n_out(module_alert_n_out),
  .low_power_out(low_power_out), .sda_oe_n_out(sda_oe_n_out),
  .tx_eq_out(tx_eq_out), .rx_emph_out(rx_emph_out), .rx_amp_out(rx_amp_out));
